// ---- hdl/sbc_pkg.sv ----
// shared constants, types and address helpers for the serial register bank
// assumes a 7-bit register address space and byte-wide registers
package sbc_pkg;

  localparam int NUM_REGS = 128;
  localparam int FRAME_SHORT = 16;
  localparam int FRAME_LONG = 32;
  localparam int ACCESS_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam int MODE_LSB = 6;
  localparam int AUX_LSB = 3;
  localparam int CAN_LSB = 0;

  localparam logic [6:0] ADDR_MODE = 7'h00;
  localparam logic [6:0] ADDR_WD = 7'h03;
  localparam logic [6:0] ADDR_BUS = 7'h04;
  localparam logic [6:0] CTRL_LAST = 7'h1e;
  localparam logic [6:0] SWK_FIRST = 7'h20;
  localparam logic [6:0] SWK_LAST = 7'h3f;
  localparam logic [6:0] STAT_FIRST = 7'h40;
  localparam logic [6:0] STAT_LAST = 7'h7e;
  localparam logic [6:0] ADDR_WAKE_LVL = 7'h48;
  localparam logic [6:0] ADDR_FAM_PROD = 7'h70;
  localparam logic [6:0] ADDR_OSC_HIGH = 7'h71;
  localparam logic [6:0] ADDR_OSC_LOW = 7'h72;
  localparam logic [6:0] ADDR_SELWAKE_STATUS = 7'h73;
  localparam logic [6:0] ADDR_SWK_ECNT = 7'h74;
  localparam logic [6:0] ADDR_CDR_A = 7'h75;
  localparam logic [6:0] ADDR_CDR_B = 7'h76;

  // one bit per address, set where a register really exists
  localparam logic [127:0] EXIST_MAP =
    128'h7fff_0000_0030_ffff_ffff_ffff_0000_ffff;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_RESTART = 2'h3;
  localparam logic [1:0] AUX_OFF = 2'h0;
  localparam logic [1:0] CAN_OFF = 2'h0;
  localparam logic [1:0] CAN_WAKE = 2'h1;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_INIT, OP_NORMAL, OP_STOP, OP_SLEEP, OP_RESTART
  } op_mode_t;

  // {found, address} of the first existing register in [a, last]
  function automatic logic [7:0] next_existing(input logic [6:0] a,
                                               input logic [6:0] last);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NUM_REGS - 1; i >= 0; i--) begin
      if (i >= a && i <= last && EXIST_MAP[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction : next_existing

  // registers whose content is a live level or fixed value
  function automatic logic is_fixed(input logic [6:0] a);
    return a == ADDR_WAKE_LVL || a == ADDR_FAM_PROD || a == ADDR_OSC_HIGH ||
           a == ADDR_OSC_LOW || a == ADDR_SELWAKE_STATUS || a == ADDR_SWK_ECNT ||
           a == ADDR_CDR_A || a == ADDR_CDR_B;
  endfunction : is_fixed

endpackage : sbc_pkg

// ---- hdl/frame_if.sv ----
// frame word from the serial shifter and read bytes back from the core
// count is only sampled by the core after chip select is high; the word also feeds the read path
`timescale 1ns/10ps
`default_nettype none
interface frame_if;
  logic [31:0] word;
  logic [5:0] nbits;
  logic [23:0] rd_bytes;
  modport link (output word, output nbits, input rd_bytes);
  modport core (input word, input nbits, output rd_bytes);
endinterface : frame_if
`default_nettype wire

// ---- hdl/level_sync.sv ----
// two-stage synchroniser for levels entering the reference clock domain
// assumes the inputs are levels that stay put for several cycles
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : level_sync
`default_nettype wire

// ---- hdl/spi_shifter.sv ----
// serial shifter on the host's clock: lsb first in, answer out on falling edge
// assumes the host clock idles between frames; chip select high clears its count and output
`timescale 1ns/10ps
`default_nettype none
module spi_shifter (
  // serial pins
  input wire logic spi_clk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  // toward the register core
  frame_if.link frm
);
  import sbc_pkg::*;

  logic [31:0] word_q, word_d;
  logic [5:0] cnt_q, cnt_d;
  logic [5:0] len_q;
  logic sdo_q, sdo_d;
  logic [31:0] tx;

  always_comb begin
    word_d = word_q;
    cnt_d = cnt_q;
    if (cnt_q < 6'(FRAME_LONG)) begin
      word_d[cnt_q[4:0]] = spi_sdi;
    end
    // saturate so a long frame still reads as a bad length
    if (cnt_q <= 6'(FRAME_LONG)) begin
      cnt_d = cnt_q + 6'h01;
    end
  end

  // the word is not cleared: the core reads it after chip select rises
  always_ff @(posedge spi_clk) begin
    word_q <= word_d;
  end

  always_ff @(posedge spi_clk or posedge spi_csn) begin
    if (spi_csn) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // the count is cleared as chip select rises, so the frame length is caught
  // on that same edge; the core reads it a few reference cycles later
  always_ff @(posedge spi_csn) begin
    len_q <= cnt_q;
  end

  // low byte carries no status here; data bytes follow the address byte
  assign tx = {frm.rd_bytes, 8'h00};

  always_comb begin
    sdo_d = 1'b0;
    if (cnt_q < 6'(FRAME_LONG)) begin
      sdo_d = tx[cnt_q[4:0]];
    end
  end

  always_ff @(negedge spi_clk or posedge spi_csn) begin
    if (spi_csn) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  assign frm.word = word_q;
  assign frm.nbits = len_q;
  assign spi_sdo = sdo_q;
endmodule : spi_shifter
`default_nettype wire

// ---- hdl/sbc_spi_register_access.sv ----
// register bank behind the serial host port of a system basis device
// assumes the host keeps its clock still while chip select is high
//
// Operation
// - long frames only for selective-wake addresses; short frames elsewhere
// - oscillator trim status registers never reached by long frames
// - reserved address hits the next existing register of its range instead, if there is one
// - bytes beyond address space are ignored and read as zero
// - control access bit 0 reads only, 1 reads and writes
// - written control value is visible only in a later frame
// - status read returns contents; access bit 1 also clears the byte
// - level, identity and selective-wake status registers ignore clears
// - drivers may be enabled while failure flags are still set
// - mode field always shows the operating mode actually in effect
// - low-power entry keeps diagnosis bits and an active fail output
// - stop entry leaves bus transceiver control bits unchanged
// - sleep entry sets transceiver bits that are neither off nor wake capable to wake capable
// - auxiliary regulator stays on in low power; failure turns it off
// - restart clears auxiliary regulator config; fail output stays active
// - address in bits 6..0, access bit 7, data in bits 15..8
// - changes from a frame take effect when chip select rises
// - writes only in init and normal; stop allows normal, watchdog, status
`timescale 1ns/10ps
`default_nettype none
module sbc_spi_register_access #(
  parameter logic [7:0] FAMILY_ID = 8'h5a  // arbitrary identity value
) (
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial host port
  input wire logic spi_clk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // hardware status events, same clock; wake pin levels are synchronised here
  input wire logic evt_valid,
  input wire logic [6:0] evt_addr,
  input wire logic [7:0] evt_bits,
  input wire logic [7:0] wake_pin_level,
  // mode events and supervision, same clock
  input wire logic mode_force_valid,
  input wire sbc_pkg::op_mode_t mode_force,
  input wire logic fail_trigger,
  input wire logic aux_fail,
  // device controls
  output sbc_pkg::op_mode_t op_mode,
  output logic [1:0] can_mode,
  output logic [1:0] aux_reg_cfg,
  output logic fail_output,
  output logic wd_trigger
);
  import sbc_pkg::*;

  frame_if frm ();

  logic csn_s;
  logic csn_prev_q;
  logic [7:0] wake_s;
  logic frame_end;
  logic sdo_oe_q;

  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  op_mode_t state_q, state_d;
  logic fail_q, fail_d;
  logic wd_q, wd_d;

  logic [31:0] w;
  logic [6:0] a0;
  logic is_long;
  logic len_ok;
  logic long_ok;
  logic in_swk;
  logic [6:0] region_last;
  logic [7:0] rsel [3];
  logic req_valid;
  logic [1:0] req_code;
  logic clr_hit;
  logic [6:0] clr_addr;

  spi_shifter u_shifter (
    .spi_clk(spi_clk),
    .spi_csn(spi_csn),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .frm(frm.link)
  );

  level_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_csn_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din(spi_csn),
    .dout(csn_s)
  );

  level_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_wake_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din(wake_pin_level),
    .dout(wake_s)
  );

  function automatic logic [1:0] mode_code(input op_mode_t m);
    logic [1:0] c;
    c = MODE_NORMAL;
    unique case (m)
      OP_INIT, OP_NORMAL: c = MODE_NORMAL;
      OP_STOP: c = MODE_STOP;
      OP_SLEEP: c = MODE_SLEEP;
      OP_RESTART: c = MODE_RESTART;
    endcase
    return c;
  endfunction : mode_code

  function automatic op_mode_t code_mode(input logic [1:0] c);
    op_mode_t m;
    m = OP_NORMAL;
    unique case (c)
      MODE_NORMAL: m = OP_NORMAL;
      MODE_STOP: m = OP_STOP;
      MODE_SLEEP: m = OP_SLEEP;
      MODE_RESTART: m = OP_RESTART;
    endcase
    return m;
  endfunction : code_mode

  // the shifted word is quiet here since the host clock has stopped
  assign frame_end = csn_s && !csn_prev_q;

  // frame decode, shared by the read path and the update at frame end
  assign w = frm.word;
  assign a0 = w[6:0];
  assign is_long = frm.nbits == 6'(FRAME_LONG);
  assign len_ok = frm.nbits == 6'(FRAME_SHORT) || is_long;
  assign in_swk = a0 >= SWK_FIRST && a0 <= SWK_LAST;
  assign long_ok = in_swk && a0 != ADDR_OSC_HIGH && a0 != ADDR_OSC_LOW;

  always_comb begin
    region_last = STAT_LAST;
    if (a0 <= CTRL_LAST) begin
      region_last = CTRL_LAST;
    end else if (a0 <= SWK_LAST) begin
      region_last = SWK_LAST;
    end
  end

  always_comb begin
    rsel[0] = next_existing(a0, region_last);
    rsel[1] = 8'h00;
    rsel[2] = 8'h00;
    // running past the selective-wake range finds nothing: zero, no write
    if (in_swk && rsel[0][7]) begin
      rsel[1] = next_existing(7'(rsel[0][6:0] + 7'h01), SWK_LAST);
    end
    if (in_swk && rsel[1][7]) begin
      rsel[2] = next_existing(7'(rsel[1][6:0] + 7'h01), SWK_LAST);
    end
  end

  // answers come from stored values, so a write shows up a frame later
  always_comb begin
    frm.rd_bytes = 24'h00_0000;
    for (int k = 0; k < 3; k++) begin
      if (rsel[k][7]) begin
        frm.rd_bytes[8*k +: 8] = regs_q[rsel[k][6:0]];
      end
    end
  end

  always_comb begin
    logic [6:0] a;
    logic [7:0] dat;
    logic ctrl_ok;
    logic stat_ok;
    a = 7'h00;
    dat = 8'h00;
    ctrl_ok = state_q == OP_INIT || state_q == OP_NORMAL;
    stat_ok = ctrl_ok || state_q == OP_STOP;
    regs_d = regs_q;
    state_d = state_q;
    wd_d = 1'b0;
    req_valid = 1'b0;
    req_code = MODE_NORMAL;
    clr_hit = 1'b0;
    clr_addr = 7'h00;
    // an active fail output is only released by reset
    fail_d = fail_q || fail_trigger;
    if (frame_end && len_ok && (!is_long || long_ok) && w[ACCESS_BIT]) begin
      for (int k = 0; k < 3; k++) begin
        a = rsel[k][6:0];
        dat = w[DATA_LSB + 8*k +: 8];
        if ((k == 0 || is_long) && rsel[k][7]) begin
          if (a < STAT_FIRST) begin
            if (a == ADDR_MODE) begin
              if (ctrl_ok) begin
                regs_d[a] = dat;
                req_valid = 1'b1;
                req_code = dat[MODE_LSB +: 2];
              end else if (state_q == OP_STOP &&
                           dat[MODE_LSB +: 2] == MODE_NORMAL) begin
                req_valid = 1'b1;
                req_code = MODE_NORMAL;
              end
            end else if (a == ADDR_WD && stat_ok) begin
              regs_d[a] = dat;
              wd_d = 1'b1;
            end else if (ctrl_ok) begin
              regs_d[a] = dat;
            end
          end else if (stat_ok && !is_fixed(a)) begin
            regs_d[a] = REG_RESET;
            clr_hit = 1'b1;
            clr_addr = a;
          end
        end
      end
    end
    // events land after the clear, so a set in the clearing cycle wins
    if (evt_valid) begin
      if (is_fixed(evt_addr)) begin
        regs_d[evt_addr] = evt_bits;
      end else begin
        regs_d[evt_addr] = regs_d[evt_addr] | evt_bits;
      end
    end
    regs_d[ADDR_WAKE_LVL] = wake_s;
    regs_d[ADDR_FAM_PROD] = FAMILY_ID;
    if (mode_force_valid) begin
      state_d = mode_force;
    end else if (req_valid) begin
      state_d = code_mode(req_code);
    end
    if (state_d != state_q) begin
      unique case (state_d)
        OP_SLEEP: begin
          if (regs_d[ADDR_BUS][CAN_LSB +: 2] != CAN_OFF &&
              regs_d[ADDR_BUS][CAN_LSB +: 2] != CAN_WAKE) begin
            regs_d[ADDR_BUS][CAN_LSB +: 2] = CAN_WAKE;
          end
        end
        OP_RESTART: regs_d[ADDR_MODE][AUX_LSB +: 2] = AUX_OFF;
        // stop and the rest keep transceiver and diagnosis bits as they are
        default: ;
      endcase
    end
    // a regulator failure switches it off without any mode change
    if (aux_fail) begin
      regs_d[ADDR_MODE][AUX_LSB +: 2] = AUX_OFF;
    end
    regs_d[ADDR_MODE][MODE_LSB +: 2] = mode_code(state_d);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
      state_q <= OP_INIT;
      fail_q <= 1'b0;
      wd_q <= 1'b0;
      csn_prev_q <= 1'b1;
      sdo_oe_q <= 1'b0;
    end else begin
      regs_q <= regs_d;
      state_q <= state_d;
      fail_q <= fail_d;
      wd_q <= wd_d;
      csn_prev_q <= csn_s;
      sdo_oe_q <= !csn_s;
    end
  end

  // driver enables do not look at failure flags
  assign can_mode = regs_q[ADDR_BUS][CAN_LSB +: 2];
  assign aux_reg_cfg = regs_q[ADDR_MODE][AUX_LSB +: 2];
  assign op_mode = state_q;
  assign fail_output = fail_q;
  assign wd_trigger = wd_q;
  assign spi_sdo_oe = sdo_oe_q;

  property p_mode_field;
    @(posedge ref_clk) disable iff (!rst_n)
    regs_q[ADDR_MODE][MODE_LSB +: 2] == mode_code(state_q);
  endproperty
  a_mode_field: assert property (p_mode_field)
    else $error("mode field differs from operating mode");

  property p_sleep_can;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == OP_SLEEP && $past(state_q) != OP_SLEEP) |->
      (can_mode == CAN_OFF || can_mode == CAN_WAKE);
  endproperty
  a_sleep_can: assert property (p_sleep_can)
    else $error("transceiver still active after sleep entry");

  property p_stop_can;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == OP_STOP && $past(state_q) != OP_STOP) |->
      can_mode == $past(can_mode);
  endproperty
  a_stop_can: assert property (p_stop_can)
    else $error("transceiver bits changed on stop entry");

  property p_aux_fail;
    @(posedge ref_clk) disable iff (!rst_n)
    (aux_fail && !mode_force_valid && !frame_end) |=>
      (aux_reg_cfg == AUX_OFF && state_q == $past(state_q));
  endproperty
  a_aux_fail: assert property (p_aux_fail)
    else $error("regulator failure not handled quietly");

  property p_restart_aux;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(state_q == OP_RESTART) |-> aux_reg_cfg == AUX_OFF;
  endproperty
  a_restart_aux: assert property (p_restart_aux)
    else $error("regulator config kept in restart");

  property p_fail_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    fail_output |=> fail_output [*3];
  endproperty
  a_fail_hold: assert property (p_fail_hold)
    else $error("fail output released");

  property p_stop_locked;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == OP_STOP && !mode_force_valid) |=> $stable(can_mode);
  endproperty
  a_stop_locked: assert property (p_stop_locked)
    else $error("control changed while stopped");

  property p_apply_at_end;
    @(posedge ref_clk) disable iff (!rst_n)
    (!frame_end && !mode_force_valid) |=> $stable(regs_q[ADDR_BUS]);
  endproperty
  a_apply_at_end: assert property (p_apply_at_end)
    else $error("control changed outside frame end");

  property p_wake_level;
    @(posedge ref_clk) disable iff (!rst_n)
    ##1 regs_q[ADDR_WAKE_LVL] == $past(wake_s);
  endproperty
  a_wake_level: assert property (p_wake_level)
    else $error("wake level register not live");

  property p_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    (clr_hit && !evt_valid) |=> regs_q[$past(clr_addr)] == REG_RESET;
  endproperty
  a_clear: assert property (p_clear)
    else $error("status byte not cleared");

  c_long_frame: cover property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && is_long && long_ok && w[ACCESS_BIT]);
  c_sleep_entry: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state_q == OP_SLEEP));
  c_stop_entry: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state_q == OP_STOP));
  c_aux_fail: cover property (@(posedge ref_clk) disable iff (!rst_n)
    aux_fail && state_q == OP_SLEEP);
endmodule : sbc_spi_register_access
`default_nettype wire

// ---- verification/spi_host_model.sv ----
// serial host master model: frames lsb first, answer sampled per bit
// assumes the caller spaces frames; the clock stands still between them
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // serial pins
  output var logic spi_clk,
  output var logic spi_csn,
  output var logic spi_sdi,
  input wire logic spi_sdo
);
  initial begin
    spi_clk = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
  end

  // 30 ns link clock, only inside frames; length chosen by the caller
  task automatic xfer(input int n, input logic [31:0] w,
                      output logic [31:0] r);
    r = '0;
    spi_csn = 1'b0;
    #60;
    for (int k = 0; k < n; k++) begin
      spi_sdi = w[k];
      #15;
      r[k] = spi_sdo;
      spi_clk = 1'b1;
      #15;
      spi_clk = 1'b0;
    end
    #30;
    spi_csn = 1'b1;
    // released line must not keep showing the last bit
    spi_sdi = ~spi_sdi;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ---- verification/tb_sbc_spi_register_access.sv ----
// self-checking bench for the serial register bank
// assumes the host model drives the link pins; ref inputs driven here
`timescale 1ns/10ps
`default_nettype none
module tb_sbc_spi_register_access;
  import sbc_pkg::*;
  logic ref_clk, rst_n, spi_clk, spi_csn, spi_sdi, spi_sdo, spi_sdo_oe;
  logic evt_valid, mode_force_valid, fail_trigger, aux_fail;
  logic fail_output, wd_trigger;
  logic [6:0] evt_addr;
  logic [7:0] evt_bits, wake_pin_level, v;
  logic [1:0] can_mode, aux_reg_cfg;
  op_mode_t mode_force, op_mode, md;
  int err_count, checks_done, wd_seen;
  int regs [128];

  // identity value of our own choosing, arbitrary
  localparam logic [7:0] FAM_ID = 8'h5a;

  sbc_spi_register_access #(.FAMILY_ID(FAM_ID)) i_dut (.ref_clk(ref_clk),
    .rst_n(rst_n),
    .spi_clk(spi_clk), .spi_csn(spi_csn), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .evt_valid(evt_valid),
    .evt_addr(evt_addr), .evt_bits(evt_bits),
    .wake_pin_level(wake_pin_level), .mode_force_valid(mode_force_valid),
    .mode_force(mode_force), .fail_trigger(fail_trigger),
    .aux_fail(aux_fail), .op_mode(op_mode), .can_mode(can_mode),
    .aux_reg_cfg(aux_reg_cfg), .fail_output(fail_output),
    .wd_trigger(wd_trigger));
  spi_host_model i_host (.spi_clk(spi_clk), .spi_csn(spi_csn),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wd_trigger === 1'b1) wd_seen++;
  end

  task automatic chk_rsp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch answer t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_rsp

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch output t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  function automatic bit present(int a);
    return a <= 15 || (a >= 32 && a <= 79) || a == 84 || a == 85 ||
      (a >= 112 && a <= 126);
  endfunction : present

  function automatic int resolve(int a, int last);
    for (int i = a; i <= last; i++) begin
      if (present(i)) return i;
    end
    return -1;
  endfunction : resolve

  function automatic bit fixed(int a);
    return a == 72 || (a >= 112 && a <= 118);
  endfunction : fixed

  // model computes the answer from state before the frame, then updates
  task automatic frame(input int n, input bit acc, input int a,
                       input logic [23:0] d, input bit chk);
    logic [31:0] w, r, e;
    logic [1:0] can_old;
    int ad;
    w = {d, acc, 7'(a)};
    e = '0;
    can_old = can_mode;
    wd_seen = 0;
    ad = resolve(a, a <= 30 ? 30 : (a <= 63 ? 63 : 126));
    for (int k = 0; k < n / 8 - 1 && ad >= 0; k++) begin
      e[8*k+8 +: 8] = 8'(regs[ad]);
      if (acc && (n == 16 || (a >= 32 && a <= 63))) begin
        if (ad >= 64 && !fixed(ad)) regs[ad] = 0;
        else if (ad < 64 && (md == OP_INIT || md == OP_NORMAL ||
                 (md == OP_STOP && (ad == 0 || ad == 3))))
          regs[ad] = d[8*k +: 8];
      end
      ad = resolve(ad + 1, 63);
    end
    fork
      i_host.xfer(n, w, r);
      begin
        repeat (10) @(posedge ref_clk);
        chk_out(32'(spi_sdo_oe), 32'h1);
      end
    join
    if (chk) chk_rsp(r, e);
    if (a == 4) chk_out(32'(can_mode), 32'(can_old));
    repeat (8) @(posedge ref_clk);
    chk_out(32'(spi_sdo_oe), 32'h0);
  endtask : frame

  task automatic evt(input int a, input logic [7:0] b);
    @(posedge ref_clk);
    evt_valid <= 1'b1;
    evt_addr <= 7'(a);
    evt_bits <= b;
    @(posedge ref_clk);
    evt_valid <= 1'b0;
    // the identity register always shows its fixed value
    if (a != 112) regs[a] = fixed(a) ? int'(b) : (regs[a] | int'(b));
    repeat (2) @(posedge ref_clk);
  endtask : evt

  task automatic force_mode(input op_mode_t m);
    @(posedge ref_clk);
    mode_force_valid <= 1'b1;
    mode_force <= m;
    @(posedge ref_clk);
    mode_force_valid <= 1'b0;
    md = m;
    repeat (3) @(posedge ref_clk);
  endtask : force_mode

  initial begin
    #200us;
    err_count++;
    conclude();
  end

  initial begin
    wd_seen = $urandom(32'h2ac91dfc);
    err_count = 0;
    checks_done = 0;
    md = OP_INIT;
    foreach (regs[i]) regs[i] = 0;
    regs[112] = int'(FAM_ID);
    {rst_n, evt_valid, mode_force_valid, fail_trigger, aux_fail} = '0;
    evt_addr = '0;
    evt_bits = '0;
    wake_pin_level = '0;
    mode_force = OP_NORMAL;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wake_pin_level <= 8'($urandom);
    repeat (6) @(posedge ref_clk);
    regs[72] = int'(wake_pin_level);
    chk_out(32'(op_mode), 32'(OP_INIT));
    frame(16, 0, 0, 0, 1);
    v = (8'($urandom) & 8'hfc) | 8'h02;
    frame(16, 0, 4, 24'(v), 1);
    frame(16, 1, 4, 24'(v), 1);
    frame(16, 0, 4, 0, 1);
    chk_out(32'(can_mode), 32'(v[1:0]));
    frame(16, 1, 31, 24'($urandom), 1);
    frame(16, 0, 32, 0, 1);
    frame(32, 1, 62, 24'($urandom), 1);
    frame(32, 0, 61, 0, 1);
    frame(32, 1, 4, 24'($urandom), 0);
    frame(16, 0, 4, 0, 1);
    evt(65, 8'($urandom));
    frame(16, 0, 65, 0, 1);
    frame(16, 1, 65, 0, 1);
    frame(16, 0, 65, 0, 1);
    evt(84, 8'($urandom) | 8'h01);
    frame(16, 1, 80, 0, 1);
    frame(16, 0, 84, 0, 1);
    for (int i = 112; i <= 118; i++) begin
      evt(i, 8'($urandom));
      frame(16, 1, i, 0, 1);
      frame(16, 0, i, 0, 1);
    end
    frame(16, 1, 72, 0, 1);
    frame(32, 1, 113, 0, 0);
    frame(16, 0, 113, 0, 1);
    frame(16, 1, 0, 24'h08, 1);
    md = OP_NORMAL;
    chk_out(32'(op_mode), 32'(OP_NORMAL));
    @(posedge ref_clk) fail_trigger <= 1'b1;
    @(posedge ref_clk) fail_trigger <= 1'b0;
    evt(68, 8'hff);
    frame(16, 1, 4, 24'h03, 1);
    chk_out(32'(can_mode), 32'h3);
    frame(16, 1, 0, 24'h88, 1);
    md = OP_STOP;
    chk_out(32'(op_mode), 32'(OP_STOP));
    chk_out(32'({can_mode, aux_reg_cfg, fail_output}), 32'h1b);
    frame(16, 0, 68, 0, 1);
    frame(16, 1, 4, 24'h00, 1);
    frame(16, 1, 3, 24'(v), 0);
    chk_out(32'(wd_seen), 32'h1);
    frame(16, 0, 0, 0, 1);
    frame(16, 1, 0, 24'h08, 1);
    md = OP_NORMAL;
    chk_out(32'(op_mode), 32'(OP_NORMAL));
    frame(16, 1, 0, 24'h48, 1);
    md = OP_SLEEP;
    chk_out(32'(op_mode), 32'(OP_SLEEP));
    chk_out(32'({can_mode, aux_reg_cfg, fail_output}), 32'h0b);
    force_mode(OP_RESTART);
    chk_out(32'({aux_reg_cfg, fail_output}), 32'h1);
    force_mode(OP_NORMAL);
    regs[0] = 0;
    frame(16, 1, 0, 24'h08, 1);
    @(posedge ref_clk) aux_fail <= 1'b1;
    @(posedge ref_clk) aux_fail <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_out(32'({op_mode, aux_reg_cfg}), {27'h0, OP_NORMAL, 2'h0});
    conclude();
  end
endmodule : tb_sbc_spi_register_access
`default_nettype wire
